/* File: design/rlp_pkg.sv */
// shared constants, register map and decode helpers for the rgb led pwm block
package rlp_pkg;
  localparam int NUM_MOD = 4;
  localparam int NUM_CH = 4;
  localparam int NUM_COM = 8;
  localparam int DUTY_W = 6;
  localparam int ADDR_W = 8;
  localparam int RAM_DEPTH = 128;
  // clock rates in kHz; pwm tick rate is half of the selected source
  localparam int SYS_CLK_KHZ = 20000;
  localparam int PWM_16_KHZ = 16000;
  localparam int PWM_24_KHZ = 24000;
  localparam int PWM_12_KHZ = 12000;
  localparam int PWM_ACC_W = 17;
  localparam logic [PWM_ACC_W-1:0] PWM_ACC_LIMIT = PWM_ACC_W'(2 * SYS_CLK_KHZ);
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_DUTY_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTL0 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CTL1 = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_DATA_COMS = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_COM_EN_BASE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_BASE = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_RAM_BASE = 8'h80;
  // duty register fields
  localparam int DUTY_EN_BIT = 7;
  // control zero fields
  localparam int CTL0_PULSES_LSB = 6;
  localparam int CTL0_CLKSEL_LSB = 4;
  localparam int CTL0_HWCOM_BIT = 3;
  localparam int CTL0_COMSEL_LSB = 0;
  // control one fields
  localparam int CTL1_GLOBAL_EN_BIT = 1;
  localparam logic [7:0] CTL1_MASK = 8'h02;
  localparam logic [7:0] DUTY_MASK = 8'hbf;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [1:0] CLKSEL_16 = 2'h0;
  localparam logic [1:0] CLKSEL_24 = 2'h1;
  localparam logic [1:0] CLKSEL_12 = 2'h3;

  // pulses per com from the two-bit code
  function automatic logic [2:0] rlp_pulses(input logic [1:0] code);
    case (code)
      2'h0: rlp_pulses = 3'h3;
      2'h1: rlp_pulses = 3'h2;
      2'h2: rlp_pulses = 3'h1;
      default: rlp_pulses = 3'h4;
    endcase
  endfunction : rlp_pulses
endpackage : rlp_pkg

/* File: design/rlp_tick_if.sv */
// timing signals shared by the sequencer and the colour channels
`timescale 1ns/1ps
interface rlp_tick_if;
  logic tick;
  logic run;
  logic slot_active;
  modport seq (output tick, output run, output slot_active);
  modport chan (input tick, input run, input slot_active);
endinterface : rlp_tick_if

/* File: design/rlp_channel.sv */
// one colour channel: free-running 6-bit counter against a duty value
`timescale 1ns/1ps
module rlp_channel
  import rlp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // timing
  rlp_tick_if.chan tif,
  // channel setup
  input wire logic enable,
  input wire logic [DUTY_W-1:0] duty,
  // led line
  output logic pwm_out
);
  logic [DUTY_W-1:0] count;

  // counter held at zero while the channel is off
  always_ff @(posedge clock)
  begin
    if (rst || !enable || !tif.run)
      count <= '0;
    else if (tif.tick)
      count <= count + 1'b1;
  end

  // output high while the count is below the duty
  always_ff @(posedge clock)
  begin
    if (rst)
      pwm_out <= 1'b0;
    else
      pwm_out <= enable && tif.run && tif.slot_active && (count < duty);
  end
endmodule : rlp_channel

/* File: design/rlp_com_seq.sv */
// com scanner: counts pwm periods per com and walks the selected coms
`timescale 1ns/1ps
module rlp_com_seq
  import rlp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // setup
  input wire logic run,
  input wire logic pwm_tick,
  input wire logic [1:0] pulses_per_com_select,
  input wire logic [2:0] com_count_select,
  input wire logic [2:0] data_com_count,
  // timing out
  rlp_tick_if.seq tif,
  // scan state
  output logic [2:0] com_idx,
  output logic slot_end
);
  logic [DUTY_W-1:0] phase;
  logic [2:0] pulse_cnt;
  logic period_end;

  assign tif.tick = pwm_tick && run;
  assign tif.run = run;
  // coms beyond the filled data slots stay dark
  assign tif.slot_active = (com_idx <= data_com_count);
  assign period_end = tif.tick && (phase == {DUTY_W{1'b1}});
  assign slot_end = period_end && (pulse_cnt + 3'h1 >= rlp_pulses(pulses_per_com_select));

  // pwm period phase, 64 ticks per waveform
  always_ff @(posedge clock)
  begin
    if (rst || !run)
      phase <= '0;
    else if (tif.tick)
      phase <= phase + 1'b1;
  end

  // waveforms emitted in the current com slot
  always_ff @(posedge clock)
  begin
    if (rst || !run || slot_end)
      pulse_cnt <= '0;
    else if (period_end)
      pulse_cnt <= pulse_cnt + 3'h1;
  end

  // com walk wraps after the last selected com
  always_ff @(posedge clock)
  begin
    if (rst || !run)
      com_idx <= '0;
    else if (slot_end)
      com_idx <= (com_idx >= com_count_select) ? 3'h0 : com_idx + 3'h1;
  end
endmodule : rlp_com_seq

/* File: design/rlp_top.sv */
// rgb led pwm control: registers, clock source, com scan and colour channels
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module rlp_top
  import rlp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // led matrix lines
  output logic [NUM_COM-1:0] com_out,
  output logic [NUM_MOD*NUM_CH-1:0] seg_out
);
  logic [7:0] duty_reg [NUM_MOD*NUM_CH];
  logic [7:0] ram [RAM_DEPTH];
  logic [NUM_MOD-1:0] com_en [NUM_COM];
  logic [DUTY_W-1:0] offset_reg [NUM_MOD];
  logic [7:0] led_pwm_control_zero;
  logic global_pwm_enable;
  logic [2:0] data_com_count;
  logic [PWM_ACC_W-1:0] pwm_acc;
  logic [PWM_ACC_W-1:0] next_pwm_acc;
  logic [PWM_ACC_W-1:0] clk_inc;
  logic pwm_tick;
  logic hw_com_sequencing_enable;
  logic [1:0] pwm_clock_select;
  logic [1:0] pulses_per_com_select;
  logic [2:0] com_count_select;
  logic [2:0] com_idx;
  logic slot_end;
  logic run;
  logic [7:0] rd_value;
  rlp_tick_if tif ();

  assign pulses_per_com_select = led_pwm_control_zero[CTL0_PULSES_LSB +: 2];
  assign pwm_clock_select = led_pwm_control_zero[CTL0_CLKSEL_LSB +: 2];
  assign hw_com_sequencing_enable = led_pwm_control_zero[CTL0_HWCOM_BIT];
  assign com_count_select = led_pwm_control_zero[CTL0_COMSEL_LSB +: 3];
  assign run = global_pwm_enable && (pwm_clock_select != 2'h2);

  // ram index of module m, channel c at the current com
  function automatic logic [6:0] ram_idx(input logic [2:0] com, input int unsigned slot);
    ram_idx = {com, 4'(slot)};
  endfunction : ram_idx

  // duty register index decode
  function automatic logic is_duty(input logic [ADDR_W-1:0] a);
    is_duty = (a < ADDR_DUTY_BASE + 8'(NUM_MOD * NUM_CH));
  endfunction : is_duty

  // per-com enable decode
  function automatic logic is_com_en(input logic [ADDR_W-1:0] a);
    is_com_en = (a >= ADDR_COM_EN_BASE) && (a < ADDR_OFFSET_BASE);
  endfunction : is_com_en

  // com index from the distance to the base; the base is not 8-aligned
  function automatic logic [2:0] com_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_COM_EN_BASE;
    com_slot = d[2:0];
  endfunction : com_slot

  // per-module offset decode
  function automatic logic is_offset(input logic [ADDR_W-1:0] a);
    is_offset = (a >= ADDR_OFFSET_BASE) && (a < ADDR_OFFSET_BASE + 8'(NUM_MOD));
  endfunction : is_offset

  // source clock as a fractional tick rate; 10 is reserved and gives no tick
  always_comb
  begin
    case (pwm_clock_select)
      CLKSEL_16: clk_inc = PWM_ACC_W'(PWM_16_KHZ);
      CLKSEL_24: clk_inc = PWM_ACC_W'(PWM_24_KHZ);
      CLKSEL_12: clk_inc = PWM_ACC_W'(PWM_12_KHZ);
      default: clk_inc = '0;
    endcase
    next_pwm_acc = pwm_acc + clk_inc;
  end

  // phase accumulator; the 24000 kHz source exceeds the system clock, so every source ticks at half rate
  always_ff @(posedge clock)
  begin
    if (rst || !global_pwm_enable)
    begin
      pwm_acc <= '0;
      pwm_tick <= 1'b0;
    end
    else if (next_pwm_acc >= PWM_ACC_LIMIT)
    begin
      pwm_acc <= next_pwm_acc - PWM_ACC_LIMIT;
      pwm_tick <= 1'b1;
    end
    else
    begin
      pwm_acc <= next_pwm_acc;
      pwm_tick <= 1'b0;
    end
  end

  // global control registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      led_pwm_control_zero <= RESET_VALUE;
      global_pwm_enable <= 1'b0;
      data_com_count <= 3'h7;
    end
    else if (reg_write)
    begin
      // fields are only meant to move in manual mode or with the block stopped
      if (reg_addr == ADDR_CTL0)
        led_pwm_control_zero <= reg_wdata;
      if (reg_addr == ADDR_CTL1)
        global_pwm_enable <= reg_wdata[CTL1_GLOBAL_EN_BIT];
      if (reg_addr == ADDR_DATA_COMS)
        data_com_count <= reg_wdata[2:0];
    end
  end

  // manual-mode duty registers; bit 6 never stores
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_MOD * NUM_CH; i++)
        duty_reg[i] <= RESET_VALUE;
    end
    else if (reg_write && is_duty(reg_addr) && !hw_com_sequencing_enable)
      duty_reg[reg_addr[3:0]] <= reg_wdata & DUTY_MASK;
  end

  // auto-mode per-com output enables and per-module offsets
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_COM; i++)
        com_en[i] <= '0;
      for (int i = 0; i < NUM_MOD; i++)
        offset_reg[i] <= '0;
    end
    else if (reg_write)
    begin
      if (is_com_en(reg_addr) && hw_com_sequencing_enable)
        com_en[com_slot(reg_addr)] <= reg_wdata[NUM_MOD-1:0];
      if (is_offset(reg_addr))
        offset_reg[reg_addr[1:0]] <= reg_wdata[DUTY_W-1:0];
    end
  end

  // led ram: software fills it, hardware adds each enabled module's offset to its channel 0 entry at each auto-mode slot end
  // cleared at reset so unfilled slots never drive unknown duty onto the lines
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < RAM_DEPTH; i++)
        ram[i] <= RESET_VALUE;
    end
    else
    begin
      if (hw_com_sequencing_enable && run && slot_end)
      begin
        for (int m = 0; m < NUM_MOD; m++)
          if (com_en[com_idx][m])
            ram[ram_idx(com_idx, m * NUM_CH)][DUTY_W-1:0] <=
              ram[ram_idx(com_idx, m * NUM_CH)][DUTY_W-1:0] + offset_reg[m];
      end
      if (reg_write && reg_addr >= ADDR_RAM_BASE)
        ram[reg_addr[6:0]] <= reg_wdata & DUTY_MASK;
    end
  end

  // read mux; duty registers read as zero in auto mode and com enables in manual mode
  always_comb
  begin
    rd_value = 8'h00;
    if (is_duty(reg_addr))
      rd_value = hw_com_sequencing_enable ? 8'h00 : duty_reg[reg_addr[3:0]];
    else if (reg_addr == ADDR_CTL0)
      rd_value = led_pwm_control_zero;
    else if (reg_addr == ADDR_CTL1)
      rd_value = {6'h00, global_pwm_enable, 1'b0} & CTL1_MASK;
    else if (reg_addr == ADDR_DATA_COMS)
      rd_value = {5'h00, data_com_count};
    else if (reg_addr == ADDR_STATUS)
      rd_value = {4'h0, run, com_idx};
    else if (is_com_en(reg_addr))
      rd_value = hw_com_sequencing_enable ? {4'h0, com_en[com_slot(reg_addr)]} : 8'h00;
    else if (is_offset(reg_addr))
      rd_value = {2'h0, offset_reg[reg_addr[1:0]]};
    else if (reg_addr >= ADDR_RAM_BASE)
      rd_value = ram[reg_addr[6:0]];
  end

  // read data stand for the single cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rd_value;
    else
      reg_rdata <= 8'h00;
  end

  rlp_com_seq u_seq (
    .clock(clock),
    .rst(rst),
    .run(run),
    .pwm_tick(pwm_tick),
    .pulses_per_com_select(pulses_per_com_select),
    .com_count_select(com_count_select),
    .data_com_count(data_com_count),
    .tif(tif),
    .com_idx(com_idx),
    .slot_end(slot_end)
  );

  // com drive: one-hot over the selected coms only
  always_ff @(posedge clock)
  begin
    if (rst || !run)
      com_out <= '0;
    else
      com_out <= NUM_COM'(1) << com_idx;
  end

  // one channel per module and colour; auto mode reads duty from ram
  for (genvar g = 0; g < NUM_MOD * NUM_CH; g++)
  begin : g_chan
    logic [7:0] src;
    logic ch_en;
    assign src = hw_com_sequencing_enable ? ram[ram_idx(com_idx, g)] : duty_reg[g];
    assign ch_en = hw_com_sequencing_enable ? com_en[com_idx][g / NUM_CH]
                                            : src[DUTY_EN_BIT];
    rlp_channel u_chan (
      .clock(clock),
      .rst(rst),
      .tif(tif),
      .enable(ch_en),
      .duty(src[DUTY_W-1:0]),
      .pwm_out(seg_out[g])
    );
  end
endmodule : rlp_top

/* File: verif/rlp_led_model.sv */
// led matrix model: tallies com steps and lit cycles of one segment line
`timescale 1ns/1ps
module rlp_led_model
  import rlp_pkg::*;
(
  // clock and control
  input wire logic clock,
  input wire logic clr,
  input wire logic [3:0] seg_sel,
  // led lines
  input wire logic [NUM_COM-1:0] com_out,
  input wire logic [NUM_MOD*NUM_CH-1:0] seg_out,
  // tallies
  output int n_lit,
  output int n_step
);
  logic [NUM_COM-1:0] last_com;
  // a step is a change to a new lit com; the idle zero is not a com
  always_ff @(posedge clock)
  begin
    last_com <= com_out;
    n_lit <= clr ? 0 : n_lit + int'(seg_out[seg_sel] === 1'h1);
    n_step <= clr ? 0 : n_step + int'(com_out !== last_com && com_out !== '0);
  end
endmodule : rlp_led_model

/* File: verif/rlp_top_chk.sv */
// concurrent checks on the rgb led pwm control ports
`timescale 1ns/1ps
module rlp_top_chk
  import rlp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // led lines
  input wire logic [NUM_COM-1:0] com_out,
  input wire logic [NUM_MOD*NUM_CH-1:0] seg_out
);
  logic [7:0] ctl0;
  logic gen;
  logic en3;
  logic [7:0] lit_run;
  wire logic stopped = !gen || ctl0[5:4] == 2'h2;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // shadows of the written controls, so idle windows are known
  always_ff @(posedge clock)
  begin
    if (rst) ctl0 <= 8'h00;
    else if (reg_write && reg_addr == ADDR_CTL0) ctl0 <= reg_wdata;
  end
  always_ff @(posedge clock)
  begin
    if (rst) gen <= 1'h0;
    else if (reg_write && reg_addr == ADDR_CTL1) gen <= reg_wdata[CTL1_GLOBAL_EN_BIT];
  end
  always_ff @(posedge clock)
  begin
    if (rst) en3 <= 1'h0;
    else if (reg_write && reg_addr == 8'h03 && !ctl0[3]) en3 <= reg_wdata[7];
  end
  // saturating length of a lit stretch on module 0 colour c
  always_ff @(posedge clock)
  begin
    if (rst || !seg_out[3]) lit_run <= 8'h00;
    else if (lit_run != 8'hff) lit_run <= lit_run + 8'h01;
  end
  sequence ctl0_wr_rd;
    reg_write && reg_addr == ADDR_CTL0 ##2 reg_read && reg_addr == ADDR_CTL0;
  endsequence
  chk_bit6_reads_zero: assert property (reg_read && reg_addr < 8'h10 |=> !reg_rdata[6])
    else $error("bit 6 of a duty register read as one");
  chk_duty_hidden_auto: assert property (
    ctl0[3] && reg_read && reg_addr < 8'h10 |=> reg_rdata == 8'h00)
    else $error("duty register visible in auto mode");
  chk_comen_hidden_manual: assert property (
    !ctl0[3] && reg_read && reg_addr >= 8'h14 && reg_addr < 8'h1c |=> reg_rdata == 8'h00)
    else $error("com enable visible in manual mode");
  chk_com_one_hot: assert property ($onehot0(com_out))
    else $error("more than one com line driven");
  chk_ctl0_read_back: assert property (ctl0_wr_rd |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control zero read back differs");
  chk_lit_stretch_bound: assert property (lit_run <= 8'd220)
    else $error("segment lit longer than one waveform");
  chk_stop_lines_idle: assert property (
    stopped && $past(stopped) && $past(stopped, 2) |-> com_out == '0 && seg_out == '0)
    else $error("led lines active while stopped");
  chk_disabled_chan_dark: assert property (
    !ctl0[3] && !en3 && !$past(en3) && !$past(en3, 2) && !$past(ctl0[3], 2) |-> !seg_out[3])
    else $error("disabled colour c channel lit");
endmodule : rlp_top_chk
bind rlp_top rlp_top_chk rlp_top_chk_i (.clock, .rst, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .com_out, .seg_out);

/* File: verif/test_rgb_led_pwm_com_control.sv */
// register and led line tests for the rgb led pwm control block
`timescale 1ns/1ps
module test_rgb_led_pwm_com_control;
  import rlp_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic clr = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [NUM_COM-1:0] com_out;
  logic [NUM_MOD*NUM_CH-1:0] seg_out;
  logic [1:0] ck [3] = '{2'h0, 2'h1, 2'h3};
  int ck_n [3] = '{20, 30, 15};
  int pn [4] = '{8, 12, 24, 6};
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n_lit;
  int n_step;
  rlp_top rlp_top_i (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .com_out, .seg_out);
  rlp_led_model rlp_led_model_i (.clock, .clr, .seg_sel(4'h3), .com_out, .seg_out, .n_lit,
    .n_step);
  // free-running clock, 50 ns period
  initial
  begin
    forever #25 clock = ~clock;
  end
  task automatic test_done;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // one write cycle, then an idle edge so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
    @(posedge clock);
  endtask : wr
  // data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    #1;
    compares++;
    if (reg_rdata !== e)
    begin
      n_errors++;
      $display("ERROR %0t read %h gave %h not %h", $time, a, reg_rdata, e);
    end
    @(posedge clock);
  endtask : rd
  // tally led lines for n cycles; tolerance covers start-up and phase
  task automatic run(input int n, input int lo, input int hi, input bit step);
    int v;
    clr <= 1'h1;
    @(posedge clock);
    clr <= 1'h0;
    repeat (n) @(posedge clock);
    #1;
    v = step ? n_step : n_lit;
    compares++;
    if (v < lo || v > hi)
    begin
      n_errors++;
      $display("ERROR %0t tally %0d outside %0d..%0d", $time, v, lo, hi);
    end
    $display("led test done at %0t", $time);
    @(posedge clock);
  endtask : run
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      test_done();
    end
  end
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    rd(8'h03, 8'h00);
    rd(8'h10, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'(c), 8'hff);
      rd(8'(c), 8'hbf);
    end
    rd(8'h40, 8'h00);
    wr(8'h14, 8'h0f);
    rd(8'h14, 8'h00);
    $display("register test done");
    wr(8'h03, 8'h88);
    wr(8'h10, 8'h80);
    wr(8'h11, 8'h02);
    run(1600, 175, 225, 1'b0);
    wr(8'h03, 8'h08);
    run(1600, 0, 0, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h11, 8'h00);
      wr(8'h10, {2'h2, ck[i], 1'h0, 3'h1});
      wr(8'h11, 8'h02);
      run(3200, ck_n[i] - 1, ck_n[i] + 1, 1'b1);
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h11, 8'h00);
      wr(8'h10, {2'(p), 2'h0, 1'h0, 3'h1});
      wr(8'h11, 8'h02);
      run(3840, pn[p] - 1, pn[p] + 1, 1'b1);
    end
    wr(8'h11, 8'h00);
    wr(8'h10, 8'ha1);
    wr(8'h11, 8'h02);
    run(1600, 0, 0, 1'b1);
    wr(8'h11, 8'h00);
    wr(8'h03, 8'h88);
    wr(8'h12, 8'h00);
    wr(8'h10, 8'h81);
    wr(8'h11, 8'h02);
    run(3200, 170, 230, 1'b0);
    wr(8'h11, 8'h00);
    wr(8'h10, 8'h88);
    rd(8'h03, 8'h00);
    wr(8'h83, 8'h10);
    wr(8'h84, 8'h05);
    wr(8'h1d, 8'h01);
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h01);
    wr(8'h11, 8'h02);
    run(1600, 370, 430, 1'b0);
    rd(8'h13, 8'h08);
    wr(8'h11, 8'h00);
    rd(8'h84, 8'h05);
    wr(8'h10, 8'h61);
    rd(8'h10, 8'h61);
    test_done();
  end
endmodule : test_rgb_led_pwm_com_control
